// [src/nvm_access_pkg.sv]
// Package: constants and bus carrier for the byte-wide non-volatile store.
// Assumes a single 100 MHz system clock and a core-side register port.
package nvm_access_pkg;

  localparam int STORE_DEPTH = 64;
  localparam int INDEX_W = 6;

  // Effective register addresses: {pointer high byte, offset}
  localparam logic [15:0] ADDR_IND_ONE = 16'h0000;
  localparam logic [15:0] ADDR_PTR_ONE_LOW = 16'h0001;
  localparam logic [15:0] ADDR_PTR_ONE_HIGH = 16'h0002;
  localparam logic [15:0] ADDR_IND_TWO = 16'h0003;
  localparam logic [15:0] ADDR_PTR_TWO_LOW = 16'h0004;
  localparam logic [15:0] ADDR_PTR_TWO_HIGH = 16'h0005;
  localparam logic [15:0] ADDR_IRQ_CTRL = 16'h002d;
  localparam logic [15:0] ADDR_BYTE_INDEX = 16'h002e;
  localparam logic [15:0] ADDR_BYTE_BUFFER = 16'h002f;
  localparam logic [15:0] ADDR_CONTROL = 16'h0140;

  // Control register fields
  localparam int CTL_STORE_PERMIT = 3;
  localparam int CTL_STORE_TRIG = 2;
  localparam int CTL_FETCH_PERMIT = 1;
  localparam int CTL_FETCH_TRIG = 0;

  // Interrupt control register fields
  localparam int IRQ_DONE_EN = 0;
  localparam int IRQ_SHARED_EN = 1;
  localparam int IRQ_DONE_FLAG = 2;
  localparam int IRQ_SHARED_FLAG = 3;

  // Cycle lengths in system clocks; the write figure stands in for the timer
  localparam logic [7:0] WRITE_CYCLES = 8'hc8;
  localparam logic [7:0] READ_CYCLES = 8'h02;

  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] COUNT_ONE = 8'h01;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } cycle_state_t;

endpackage : nvm_access_pkg

// [src/byte_nvm_access_ctrl.sv]
// Byte-wide non-volatile store controller with its register file.
// Assumes the core issues at most one register access per clock.
`timescale 1ns/1ns
module byte_nvm_access_ctrl (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire nvm_access_pkg::sfr_req_t sfr_req_i,
  input wire logic global_irq_mask_i,
  input wire logic irq_ack_i,
  output logic [7:0] sfr_rdata_o,
  output logic irq_take_o,
  output logic busy_o
);

  //////////////////////////////////////////////////////////////////////////////

  logic [7:0] store_mem [nvm_access_pkg::STORE_DEPTH];

  logic [7:0] ptr_one_low_reg;
  logic [7:0] ptr_one_high_reg;
  logic [7:0] ptr_two_low_reg;
  logic [7:0] ptr_two_high_reg;
  logic [nvm_access_pkg::INDEX_W-1:0] byte_index_reg;
  logic [7:0] byte_buffer_reg;
  logic store_permit_reg;
  logic fetch_permit_reg;
  logic done_en_reg;
  logic shared_en_reg;
  logic done_flag_reg;
  logic shared_flag_reg;
  logic [7:0] rdata_reg;
  nvm_access_pkg::cycle_state_t state_reg;
  nvm_access_pkg::cycle_state_t state_next;
  logic [7:0] cnt_reg;
  logic [nvm_access_pkg::INDEX_W-1:0] lat_index_reg;
  logic [7:0] lat_data_reg;

  logic [15:0] eff_addr;
  logic wr_hit;
  logic cycle_end;
  logic start_write;
  logic start_read;
  logic [7:0] read_mux;

  //////////////////////////////////////////////////////////////////////////////
  // Indirect ports resolve through their pointer pair; the core sees a plain
  // register, so the store itself never appears in its address space.

  always_comb begin
    eff_addr = sfr_req_i.addr;
    if (sfr_req_i.addr == nvm_access_pkg::ADDR_IND_ONE) begin
      eff_addr = {ptr_one_high_reg, ptr_one_low_reg};
    end else if (sfr_req_i.addr == nvm_access_pkg::ADDR_IND_TWO) begin
      eff_addr = {ptr_two_high_reg, ptr_two_low_reg};
    end
  end

  localparam logic [7:0] COUNT_ONE_L = nvm_access_pkg::COUNT_ONE;

  assign wr_hit = sfr_req_i.wr;
  assign cycle_end = (state_reg != nvm_access_pkg::ST_IDLE) && (cnt_reg == COUNT_ONE_L);

  // Permit must already be set; a write that sets permit and trigger together
  // sees the old permit and starts nothing.
  assign start_write = wr_hit && (eff_addr == nvm_access_pkg::ADDR_CONTROL)
    && sfr_req_i.wdata[nvm_access_pkg::CTL_STORE_TRIG] && store_permit_reg
    && (state_reg == nvm_access_pkg::ST_IDLE);
  assign start_read = wr_hit && (eff_addr == nvm_access_pkg::ADDR_CONTROL)
    && sfr_req_i.wdata[nvm_access_pkg::CTL_FETCH_TRIG] && fetch_permit_reg
    && (state_reg == nvm_access_pkg::ST_IDLE) && !start_write;

  //////////////////////////////////////////////////////////////////////////////
  // Pointer registers

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ptr_one_low_reg <= nvm_access_pkg::BYTE_ZERO;
      ptr_one_high_reg <= nvm_access_pkg::BYTE_ZERO;
      ptr_two_low_reg <= nvm_access_pkg::BYTE_ZERO;
      ptr_two_high_reg <= nvm_access_pkg::BYTE_ZERO;
    end else if (wr_hit) begin
      case (eff_addr)
        nvm_access_pkg::ADDR_PTR_ONE_LOW: ptr_one_low_reg <= sfr_req_i.wdata;
        nvm_access_pkg::ADDR_PTR_ONE_HIGH: ptr_one_high_reg <= sfr_req_i.wdata;
        nvm_access_pkg::ADDR_PTR_TWO_LOW: ptr_two_low_reg <= sfr_req_i.wdata;
        nvm_access_pkg::ADDR_PTR_TWO_HIGH: ptr_two_high_reg <= sfr_req_i.wdata;
        default: begin
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Index and buffer sit in sector 0

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      byte_index_reg <= '0;
    end else if (wr_hit && (eff_addr == nvm_access_pkg::ADDR_BYTE_INDEX)) begin
      byte_index_reg <= sfr_req_i.wdata[nvm_access_pkg::INDEX_W-1:0];
    end
  end

  // A finishing read overrides a software write in the same clock
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      byte_buffer_reg <= nvm_access_pkg::BYTE_ZERO;
    end else if (cycle_end && (state_reg == nvm_access_pkg::ST_READ) && fetch_permit_reg) begin
      byte_buffer_reg <= store_mem[lat_index_reg];
    end else if (wr_hit && (eff_addr == nvm_access_pkg::ADDR_BYTE_BUFFER)) begin
      byte_buffer_reg <= sfr_req_i.wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Permits live in sector 1 at the control address

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      store_permit_reg <= 1'b0;
      fetch_permit_reg <= 1'b0;
    end else if (wr_hit && (eff_addr == nvm_access_pkg::ADDR_CONTROL)) begin
      store_permit_reg <= sfr_req_i.wdata[nvm_access_pkg::CTL_STORE_PERMIT];
      fetch_permit_reg <= sfr_req_i.wdata[nvm_access_pkg::CTL_FETCH_PERMIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Cycle sequencer: the state itself is the trigger bit, so it self-clears

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      nvm_access_pkg::ST_IDLE: begin
        if (start_write) begin
          state_next = nvm_access_pkg::ST_WRITE;
        end else if (start_read) begin
          state_next = nvm_access_pkg::ST_READ;
        end
      end
      nvm_access_pkg::ST_READ: begin
        if (cycle_end) begin
          state_next = nvm_access_pkg::ST_IDLE;
        end
      end
      nvm_access_pkg::ST_WRITE: begin
        if (cycle_end) begin
          state_next = nvm_access_pkg::ST_IDLE;
        end
      end
      default: state_next = nvm_access_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state_reg <= nvm_access_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Stand-in for the free-running write timer; one clock domain keeps the
  // completion edge aligned, at the cost of a fixed cycle length.
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      cnt_reg <= nvm_access_pkg::BYTE_ZERO;
    end else if (start_write) begin
      cnt_reg <= nvm_access_pkg::WRITE_CYCLES;
    end else if (start_read) begin
      cnt_reg <= nvm_access_pkg::READ_CYCLES;
    end else if (state_reg != nvm_access_pkg::ST_IDLE) begin
      cnt_reg <= cnt_reg - COUNT_ONE_L;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      lat_index_reg <= '0;
      lat_data_reg <= nvm_access_pkg::BYTE_ZERO;
    end else if (start_write || start_read) begin
      lat_index_reg <= byte_index_reg;
      lat_data_reg <= byte_buffer_reg;
    end
  end

  // Permit checked again at the end so clearing it mid-cycle blocks the store
  always_ff @(posedge ref_clk_i) begin
    if (cycle_end && (state_reg == nvm_access_pkg::ST_WRITE) && store_permit_reg) begin
      store_mem[lat_index_reg] <= lat_data_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write-done interrupt; hardware set wins over any clear in the same clock

  logic write_done;
  assign write_done = cycle_end && (state_reg == nvm_access_pkg::ST_WRITE);

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      done_en_reg <= 1'b0;
      shared_en_reg <= 1'b0;
    end else if (wr_hit && (eff_addr == nvm_access_pkg::ADDR_IRQ_CTRL)) begin
      done_en_reg <= sfr_req_i.wdata[nvm_access_pkg::IRQ_DONE_EN];
      shared_en_reg <= sfr_req_i.wdata[nvm_access_pkg::IRQ_SHARED_EN];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      done_flag_reg <= 1'b0;
    end else if (write_done) begin
      done_flag_reg <= 1'b1;
    end else if (wr_hit && (eff_addr == nvm_access_pkg::ADDR_IRQ_CTRL)) begin
      done_flag_reg <= sfr_req_i.wdata[nvm_access_pkg::IRQ_DONE_FLAG];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      shared_flag_reg <= 1'b0;
    end else if (write_done) begin
      shared_flag_reg <= 1'b1;
    end else if (irq_ack_i) begin
      shared_flag_reg <= 1'b0;
    end else if (wr_hit && (eff_addr == nvm_access_pkg::ADDR_IRQ_CTRL)) begin
      shared_flag_reg <= sfr_req_i.wdata[nvm_access_pkg::IRQ_SHARED_FLAG];
    end
  end

  assign irq_take_o = global_irq_mask_i && shared_en_reg && shared_flag_reg
    && done_en_reg && done_flag_reg;
  assign busy_o = (state_reg != nvm_access_pkg::ST_IDLE);

  //////////////////////////////////////////////////////////////////////////////
  // Register read-back, answered one clock after the request

  always_comb begin
    read_mux = nvm_access_pkg::BYTE_ZERO;
    case (eff_addr)
      nvm_access_pkg::ADDR_PTR_ONE_LOW: read_mux = ptr_one_low_reg;
      nvm_access_pkg::ADDR_PTR_ONE_HIGH: read_mux = ptr_one_high_reg;
      nvm_access_pkg::ADDR_PTR_TWO_LOW: read_mux = ptr_two_low_reg;
      nvm_access_pkg::ADDR_PTR_TWO_HIGH: read_mux = ptr_two_high_reg;
      nvm_access_pkg::ADDR_BYTE_INDEX: read_mux = {2'h0, byte_index_reg};
      nvm_access_pkg::ADDR_BYTE_BUFFER: read_mux = byte_buffer_reg;
      nvm_access_pkg::ADDR_CONTROL: begin
        read_mux[nvm_access_pkg::CTL_STORE_PERMIT] = store_permit_reg;
        read_mux[nvm_access_pkg::CTL_STORE_TRIG] = (state_reg == nvm_access_pkg::ST_WRITE);
        read_mux[nvm_access_pkg::CTL_FETCH_PERMIT] = fetch_permit_reg;
        read_mux[nvm_access_pkg::CTL_FETCH_TRIG] = (state_reg == nvm_access_pkg::ST_READ);
      end
      nvm_access_pkg::ADDR_IRQ_CTRL: begin
        read_mux[nvm_access_pkg::IRQ_DONE_EN] = done_en_reg;
        read_mux[nvm_access_pkg::IRQ_SHARED_EN] = shared_en_reg;
        read_mux[nvm_access_pkg::IRQ_DONE_FLAG] = done_flag_reg;
        read_mux[nvm_access_pkg::IRQ_SHARED_FLAG] = shared_flag_reg;
      end
      default: read_mux = nvm_access_pkg::BYTE_ZERO;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      rdata_reg <= nvm_access_pkg::BYTE_ZERO;
    end else if (sfr_req_i.rd) begin
      rdata_reg <= read_mux;
    end
  end

  assign sfr_rdata_o = rdata_reg;

endmodule : byte_nvm_access_ctrl

// [verif/nvm_access_assertions.sv]
// Checker for the byte store controller ports.
// Assumes store triggers reach the control register by its direct address.
`timescale 1ns/1ns
module nvm_access_assertions (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire nvm_access_pkg::sfr_req_t sfr_req_i,
  input wire logic global_irq_mask_i,
  input wire logic irq_ack_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic irq_take_o,
  input wire logic busy_o
);
  logic [7:0] run_len_reg;
  logic permit_reg;
  logic ctl_wr;
  logic ctl_rd;
  assign ctl_wr = sfr_req_i.wr && sfr_req_i.addr == nvm_access_pkg::ADDR_CONTROL;
  assign ctl_rd = sfr_req_i.rd && sfr_req_i.addr == nvm_access_pkg::ADDR_CONTROL;
  // Shadow permit sees direct writes only; indirect ones would fool it
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) permit_reg <= 1'b0;
    else if (ctl_wr) permit_reg <= sfr_req_i.wdata[3];
  end
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i || !busy_o) run_len_reg <= 8'h00;
    else run_len_reg <= run_len_reg + 8'h01;
  end
  ////////////////////////////////////////
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_store_trig;
    ctl_wr && sfr_req_i.wdata[2] && !busy_o;
  endsequence
  property p_reset_quiet;
    disable iff (1'b0) !resetn_i |=> !busy_o && !irq_take_o && sfr_rdata_o == 8'h00;
  endproperty
  property p_run_len;
    $fell(busy_o) |-> run_len_reg == nvm_access_pkg::READ_CYCLES ||
      run_len_reg == nvm_access_pkg::WRITE_CYCLES;
  endproperty
  property p_no_permit;
    s_store_trig ##0 !permit_reg |=> !busy_o;
  endproperty
  property p_store_start;
    s_store_trig ##0 permit_reg |=> busy_o [*8];
  endproperty
  property p_irq_mask;
    irq_take_o |-> global_irq_mask_i;
  endproperty
  property p_ack_clear;
    irq_take_o && irq_ack_i && !busy_o |=> !irq_take_o;
  endproperty
  property p_rdata_hold;
    $changed(sfr_rdata_o) |-> $past(sfr_req_i.rd);
  endproperty
  property p_ctrl_bits;
    ctl_rd |=> sfr_rdata_o[7:4] == 4'h0 && (sfr_rdata_o[2] | sfr_rdata_o[0]) == $past(busy_o);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs not idle after reset");
  a_run_len: assert property (p_run_len)
    else $error("cycle length wrong");
  a_no_permit: assert property (p_no_permit)
    else $error("write started without permit");
  a_store_start: assert property (p_store_start)
    else $error("write did not start");
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt taken while masked");
  a_ack_clear: assert property (p_ack_clear)
    else $error("service did not drop request");
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");
  a_ctrl_bits: assert property (p_ctrl_bits)
    else $error("control readback wrong");
endmodule : nvm_access_assertions

// [verif/core_model.sv]
// Core program model: one register access per three clocks, on falling edges.
// Assumes read data is settled one clock after the access is taken.
`timescale 1ns/1ns
module core_model (
  input wire logic ref_clk_i,
  input wire logic [7:0] rdata_i,
  output nvm_access_pkg::sfr_req_t req_o,
  output logic mask_o,
  output logic ack_o
);
  logic [7:0] junk;
  initial begin
    req_o = '0;
    mask_o = 1'b0;
    ack_o = 1'b0;
  end
  ////////////////////////////////////////
  task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge ref_clk_i);
    req_o = {wr, !wr, a, d};
    @(negedge ref_clk_i);
    // Idle bus carries inverted leftovers so nothing stale looks valid
    req_o = {2'b00, ~a, ~d};
    @(negedge ref_clk_i);
    q = rdata_i;
  endtask : access
  task automatic w(input logic [15:0] a, input logic [7:0] d);
    access(1'b1, a, d, junk);
  endtask : w
  task automatic lines(input logic m, input logic k);
    @(negedge ref_clk_i);
    mask_o = m;
    ack_o = k;
    @(negedge ref_clk_i);
    ack_o = 1'b0;
  endtask : lines
  task automatic idle(output logic ok);
    logic [7:0] q;
    ok = 1'b0;
    for (int n = 0; n < 120 && !ok; n++) begin
      access(1'b0, nvm_access_pkg::ADDR_CONTROL, 8'h00, q);
      ok = (q[2] | q[0]) === 1'b0;
    end
  endtask : idle
  task automatic start(input logic [7:0] i, input logic [7:0] d);
    w(nvm_access_pkg::ADDR_BYTE_INDEX, i);
    w(nvm_access_pkg::ADDR_BYTE_BUFFER, d);
    mask_o = 1'b0;
    w(nvm_access_pkg::ADDR_CONTROL, 8'h08);
    w(nvm_access_pkg::ADDR_CONTROL, 8'h0c);
    mask_o = 1'b1;
  endtask : start
  task automatic store(input logic [7:0] i, input logic [7:0] d, output logic ok);
    start(i, d);
    idle(ok);
    w(nvm_access_pkg::ADDR_CONTROL, 8'h00);
  endtask : store
  task automatic fetch(input logic [7:0] i, output logic [7:0] q, output logic ok);
    w(nvm_access_pkg::ADDR_BYTE_INDEX, i);
    w(nvm_access_pkg::ADDR_PTR_ONE_LOW, 8'h40);
    w(nvm_access_pkg::ADDR_PTR_ONE_HIGH, 8'h01);
    w(nvm_access_pkg::ADDR_IND_ONE, 8'h02);
    w(nvm_access_pkg::ADDR_IND_ONE, 8'h03);
    idle(ok);
    w(nvm_access_pkg::ADDR_CONTROL, 8'h00);
    w(nvm_access_pkg::ADDR_PTR_ONE_HIGH, 8'h00);
    access(1'b0, nvm_access_pkg::ADDR_BYTE_BUFFER, 8'h00, q);
  endtask : fetch
endmodule : core_model

// [verif/byte_nvm_access_ctrl_tb.sv]
// Testbench for the byte store controller, driven through the core model.
// Assumes checker and core model are compiled before this file.
`timescale 1ns/1ns
`define CHK(w, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s expected %h seen %h", w, e, g); end end
module byte_nvm_access_ctrl_tb;
  logic ref_clk_i;
  logic resetn_i;
  nvm_access_pkg::sfr_req_t req;
  logic mask;
  logic ack;
  logic [7:0] rdata;
  logic take;
  logic busy;
  logic [7:0] q;
  logic ok;
  int errors;
  int compares;
  byte_nvm_access_ctrl i_byte_nvm_access_ctrl (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .sfr_req_i(req), .global_irq_mask_i(mask), .irq_ack_i(ack), .sfr_rdata_o(rdata),
    .irq_take_o(take), .busy_o(busy));
  core_model i_core_model (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .req_o(req),
    .mask_o(mask), .ack_o(ack));
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  ////////////////////////////////////////
  task automatic rd(input logic [15:0] a);
    i_core_model.access(1'b0, a, 8'h00, q);
  endtask : rd
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    i_core_model.w(a, d);
  endtask : wr
  task automatic t_fields;
    rd(nvm_access_pkg::ADDR_PTR_ONE_HIGH);
    `CHK("pointer high", 8'h00, q)
    rd(nvm_access_pkg::ADDR_CONTROL);
    `CHK("control reset", 8'h00, q)
    wr(nvm_access_pkg::ADDR_BYTE_INDEX, 8'hff);
    rd(nvm_access_pkg::ADDR_BYTE_INDEX);
    `CHK("index", 8'h3f, q)
    wr(nvm_access_pkg::ADDR_CONTROL, 8'hf2);
    rd(nvm_access_pkg::ADDR_CONTROL);
    `CHK("control", 8'h02, q)
    rd(nvm_access_pkg::ADDR_PTR_TWO_HIGH);
    `CHK("pointer two high", 8'h00, q)
    wr(nvm_access_pkg::ADDR_PTR_TWO_LOW, 8'h2f);
    wr(nvm_access_pkg::ADDR_IND_TWO, 8'h5c);
    rd(nvm_access_pkg::ADDR_BYTE_BUFFER);
    `CHK("indirect two", 8'h5c, q)
    wr(16'h0150, 8'haa);
    rd(16'h0150);
    `CHK("unmapped", 8'h00, q)
  endtask : t_fields
  task automatic t_refused;
    i_core_model.store(8'h05, 8'h11, ok);
    `CHK("store done", 1'b1, ok)
    wr(nvm_access_pkg::ADDR_BYTE_BUFFER, 8'h5a);
    wr(nvm_access_pkg::ADDR_CONTROL, 8'h0c);
    `CHK("no start", 1'b0, busy)
    wr(nvm_access_pkg::ADDR_CONTROL, 8'h00);
    wr(nvm_access_pkg::ADDR_CONTROL, 8'h04);
    `CHK("no permit", 1'b0, busy)
    i_core_model.fetch(8'h05, q, ok);
    `CHK("store kept", 8'h11, q)
  endtask : t_refused
  task automatic t_round_trip;
    for (int n = 0; n < 2; n++) begin
      i_core_model.store(8'(n * 63), 8'(n * 63) ^ 8'ha5, ok);
      i_core_model.fetch(8'(n * 63), q, ok);
      `CHK("read back", 8'(n * 63) ^ 8'ha5, q)
      rd(nvm_access_pkg::ADDR_BYTE_INDEX);
      rd(nvm_access_pkg::ADDR_BYTE_BUFFER);
      `CHK("buffer kept", 8'(n * 63) ^ 8'ha5, q)
    end
  endtask : t_round_trip
  task automatic t_fetch_refused;
    wr(nvm_access_pkg::ADDR_BYTE_INDEX, 8'h00);
    wr(nvm_access_pkg::ADDR_BYTE_BUFFER, 8'h77);
    wr(nvm_access_pkg::ADDR_CONTROL, 8'h01);
    `CHK("fetch idle", 1'b0, busy)
    rd(nvm_access_pkg::ADDR_BYTE_BUFFER);
    `CHK("buffer", 8'h77, q)
  endtask : t_fetch_refused
  task automatic t_busy_ignore;
    i_core_model.start(8'h0a, 8'h3c);
    wr(nvm_access_pkg::ADDR_BYTE_INDEX, 8'h0b);
    wr(nvm_access_pkg::ADDR_CONTROL, 8'h0e);
    i_core_model.idle(ok);
    `CHK("write end", 1'b1, ok)
    wr(nvm_access_pkg::ADDR_CONTROL, 8'h00);
    i_core_model.fetch(8'h0a, q, ok);
    `CHK("latched", 8'h3c, q)
  endtask : t_busy_ignore
  task automatic t_irq;
    wr(nvm_access_pkg::ADDR_IRQ_CTRL, 8'h03);
    i_core_model.store(8'h01, 8'h42, ok);
    `CHK("irq taken", 1'b1, take)
    i_core_model.lines(1'b0, 1'b0);
    `CHK("irq masked", 1'b0, take)
    i_core_model.lines(1'b1, 1'b1);
    `CHK("irq serviced", 1'b0, take)
    rd(nvm_access_pkg::ADDR_IRQ_CTRL);
    `CHK("irq flags", 8'h07, q)
    wr(nvm_access_pkg::ADDR_IRQ_CTRL, 8'h03);
    rd(nvm_access_pkg::ADDR_IRQ_CTRL);
    `CHK("done flag clear", 8'h03, q)
  endtask : t_irq
  task automatic t_mid_reset;
    i_core_model.start(8'h14, 8'h99);
    resetn_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    resetn_i = 1'b1;
    `CHK("busy", 1'b0, busy)
    rd(nvm_access_pkg::ADDR_CONTROL);
    `CHK("control", 8'h00, q)
  endtask : t_mid_reset
  task automatic tally_and_finish;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    errors = 0;
    compares = 0;
    resetn_i = 1'b0;
    repeat (16) @(negedge ref_clk_i);
    resetn_i = 1'b1;
    t_fields();
    t_refused();
    t_round_trip();
    t_fetch_refused();
    t_busy_ignore();
    t_irq();
    t_mid_reset();
    tally_and_finish();
  end
  initial begin
    repeat (30000) @(posedge ref_clk_i);
    errors++;
    tally_and_finish();
  end
endmodule : byte_nvm_access_ctrl_tb
bind byte_nvm_access_ctrl nvm_access_assertions i_nvm_access_assertions (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .sfr_req_i(sfr_req_i),
  .global_irq_mask_i(global_irq_mask_i), .irq_ack_i(irq_ack_i), .sfr_rdata_o(sfr_rdata_o),
  .irq_take_o(irq_take_o), .busy_o(busy_o));
